/* sea_clkdiv.sv */
// Divider giving one-cycle tick pulses, each a half period of the serial clock.
// Assumes the divide value is held steady while a transfer runs.
`timescale 1ns/100ps
`default_nettype none
module sea_clkdiv #(
   parameter int unsigned DW = sea_pkg::DIV_W
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   // Divide value: tick every (div + 1) clocks
   input  wire logic [DW-1:0] i_div,
   output logic               o_tick
);
   typedef struct packed {
      logic [DW-1:0] cnt;
      logic          tick;
   } sea_div_s;

   sea_div_s s_r;
   sea_div_s s_nxt;

   assign o_tick = s_r.tick;

   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.cnt >= i_div)
      begin
         s_nxt.cnt  = '0;
         s_nxt.tick = 1'b1;
      end
      else
         s_nxt.cnt = s_r.cnt + 1'b1;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule // sea_clkdiv
`default_nettype wire

/* sea_fifo.sv */
// Small synchronous FIFO carrying loaded words toward the register file.
// Assumes one clock; both sides use valid/ready, a word moves when both are high.
`timescale 1ns/100ps
`default_nettype none
module sea_fifo #(
   parameter int unsigned W     = 22,
   parameter int unsigned DEPTH = sea_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // Fill side
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   // Drain side
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   localparam int unsigned PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW:0]             wr;
      logic [PW:0]             rd;
   } sea_fifo_s;

   sea_fifo_s s_r;
   sea_fifo_s s_nxt;
   logic      full;
   logic      empty;

   // Pointers carry one extra wrap bit so full and empty are exact
   assign empty       = (s_r.wr == s_r.rd);
   assign full        = (s_r.wr[PW-1:0] == s_r.rd[PW-1:0]) && (s_r.wr[PW] != s_r.rd[PW]);
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = s_r.mem[s_r.rd[PW-1:0]];

   always_comb
   begin
      s_nxt = s_r;
      if (i_in_valid && !full)
      begin
         s_nxt.mem[s_r.wr[PW-1:0]] = i_in_data;
         s_nxt.wr = s_r.wr + 1'b1;
      end
      if (i_out_ready && !empty)
      begin
         s_nxt.rd = s_r.rd + 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule // sea_fifo
`default_nettype wire

/* sea_loader.sv */
// Master for a three-wire serial memory: autoload after reset, plus guarded word writes.
// Assumes the data-in line has a pull-up and that the register file drains the word stream.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Every read or write frame moves one whole 16-bit word per addressed index; enable and disable frames carry no word.
// - After reset, words from index 01h onward are copied out to configuration registers.
// - Index 00h holds the signature; a mismatch marks the memory absent, no further access.
// - Network writes to indices 00h through 10h are always refused.
// - Commands: read 10, write enable 0011, write 01, write disable 0000.
// - Undriven data-in reads as one because of its pull-up.
// - Select and data-out change only while serial clock is low; data-in sampled rising.
// - After command and address of a read, the word is shifted in serially.
// - A write enable frame always precedes the write frame.
// - After write data, select drops once, rises again, and data-in is watched.
// - Write ends once data-in is seen high or the poll limit is reached.
// - A write disable frame follows every finished write.
// - Autoload starts at reset with the word at address 0.
// - Matching signature: successive words are read and each handed to its register.
// - Missing memory or bad signature stops the autoload and loads nothing.
// - Hardware address words come from indices 01h to 03h in order.
// - Network address high at 11h, low at 12h, then netmask and gateway pairs.
// - Indices 24h to 27h hold the four communication setting words in order.
// - Serial clock is the system clock divided by twice (memory clock divider field + 1).
module sea_loader #(
   parameter logic [15:0] SIGNATURE  = 16'h5a3c, // Arbitrary value
   parameter logic [5:0]  LAST_LOAD  = sea_pkg::IDX_LAST_LOAD,
   parameter logic [15:0] POLL_LIMIT = sea_pkg::POLL_LIMIT
) (
   // Clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_RST,
   // Memory clock divider field of the general control register
   input  wire logic [7:0]  I_MEM_CLOCK_DIVIDER,
   // Serial memory pins
   output logic             O_MEMORY_SERIAL_CLOCK,
   output logic             O_MEMORY_SELECT,
   output logic             O_MEMORY_DATA_OUT,
   input  wire logic        I_MEMORY_DATA_IN,
   // Network rewrite requests
   input  wire logic        I_WR_VALID,
   input  wire logic [5:0]  I_WR_INDEX,
   input  wire logic [15:0] I_WR_DATA,
   output logic             O_WR_READY,
   output logic             O_WR_REFUSED,
   output logic             O_WR_DONE,
   output logic             O_WR_TIMEOUT,
   // Loaded configuration words
   output logic             O_CFG_VALID,
   output logic [5:0]       O_CFG_INDEX,
   output logic [15:0]      O_CFG_DATA,
   input  wire logic        I_CFG_READY,
   // Status
   output logic             O_LOAD_DONE,
   output logic             O_MEMORY_ABSENT
);
   typedef struct packed {
      sea_pkg::sea_state_e st;
      sea_pkg::sea_op_e    op;
      logic                sk;
      logic                cs;
      logic                dout;
      logic [24:0]         sh;
      logic [4:0]          last;
      logic [4:0]          cnt;
      logic [15:0]         pcnt;
      logic [15:0]         rx;
      logic [5:0]          idx;
      logic [15:0]         wdata;
      logic                loaded;
      logic                absent;
      logic                refused;
      logic                done;
      logic                tmo;
   } sea_loader_s;

   sea_loader_s s_r;
   sea_loader_s s_nxt;
   logic        tick;
   logic        push;
   logic        fifo_in_ready;
   logic [24:0] frame;
   logic [4:0]  frame_last;

   sea_clkdiv #(
      .DW     (sea_pkg::DIV_W)
   ) u_div (
      .i_clk  (I_CLK),
      .i_rst  (I_RST),
      .i_div  (I_MEM_CLOCK_DIVIDER),
      .o_tick (tick)
   );

   // Each loaded word leaves with its index so the register file maps it
   sea_fifo #(
      .W           (22),
      .DEPTH       (sea_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (I_CLK),
      .i_rst       (I_RST),
      .i_in_valid  (push),
      .i_in_data   ({s_r.idx, s_r.rx}),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (O_CFG_VALID),
      .o_out_data  ({O_CFG_INDEX, O_CFG_DATA}),
      .i_out_ready (I_CFG_READY)
   );

   // Frame image, shifted out MSB first
   always_comb
   begin
      frame      = '0;
      frame_last = sea_pkg::LAST_BIT_DATA;
      case (s_r.op)
         sea_pkg::OP_READ:
            frame = {sea_pkg::START_BIT, sea_pkg::CODE_READ, s_r.idx, 16'h0000};
         sea_pkg::OP_WRITE:
            frame = {sea_pkg::START_BIT, sea_pkg::CODE_WRITE, s_r.idx, s_r.wdata};
         sea_pkg::OP_WREN:
         begin
            frame      = {sea_pkg::START_BIT, sea_pkg::CODE_WREN, 20'h00000};
            frame_last = sea_pkg::LAST_BIT_CMD;
         end
         sea_pkg::OP_WRDIS:
         begin
            frame      = {sea_pkg::START_BIT, sea_pkg::CODE_WRDIS, 20'h00000};
            frame_last = sea_pkg::LAST_BIT_CMD;
         end
         default:
            frame = '0;
      endcase
   end

   always_comb
   begin
      s_nxt         = s_r;
      s_nxt.refused = 1'b0;
      s_nxt.done    = 1'b0;
      s_nxt.tmo     = 1'b0;
      push          = 1'b0;
      case (s_r.st)
         sea_pkg::ST_BOOT:
         begin
            s_nxt.op  = sea_pkg::OP_READ;
            s_nxt.idx = sea_pkg::IDX_SIGNATURE;
            s_nxt.cnt = '0;
            s_nxt.st  = sea_pkg::ST_GAP;
         end
         sea_pkg::ST_IDLE:
         begin
            if (I_WR_VALID)
            begin
               // An absent memory takes no access at all
               if (s_r.absent || (I_WR_INDEX <= sea_pkg::IDX_PROTECT_LAST))
                  s_nxt.refused = 1'b1;
               else
               begin
                  s_nxt.idx   = I_WR_INDEX;
                  s_nxt.wdata = I_WR_DATA;
                  s_nxt.op    = sea_pkg::OP_WREN;
                  s_nxt.cnt   = '0;
                  s_nxt.st    = sea_pkg::ST_GAP;
               end
            end
         end
         sea_pkg::ST_GAP:
         begin
            // Select stays low for a full serial clock period; reads also wait for FIFO room
            if (tick)
            begin
               if (s_r.cnt[1:0] != (sea_pkg::GAP_TICKS - 2'h1))
                  s_nxt.cnt = s_r.cnt + 5'h01;
               else if ((s_r.op != sea_pkg::OP_READ) || fifo_in_ready)
               begin
                  s_nxt.cs   = 1'b1;
                  s_nxt.sh   = frame;
                  s_nxt.dout = frame[24];
                  s_nxt.last = frame_last;
                  s_nxt.cnt  = '0;
                  s_nxt.st   = sea_pkg::ST_SHIFT;
               end
            end
         end
         sea_pkg::ST_SHIFT:
         begin
            if (tick && !s_r.sk)
            begin
               s_nxt.sk = 1'b1;
               s_nxt.rx = {s_r.rx[14:0], I_MEMORY_DATA_IN};
            end
            else if (tick)
            begin
               s_nxt.sk = 1'b0;
               if (s_r.cnt != s_r.last)
               begin
                  s_nxt.cnt  = s_r.cnt + 5'h01;
                  s_nxt.sh   = {s_r.sh[23:0], 1'b0};
                  s_nxt.dout = s_r.sh[23];
               end
               else
               begin
                  s_nxt.cs   = 1'b0;
                  s_nxt.dout = 1'b0;
                  s_nxt.cnt  = '0;
                  case (s_r.op)
                     sea_pkg::OP_READ:
                     begin
                        if (s_r.idx == sea_pkg::IDX_SIGNATURE)
                        begin
                           // No memory leaves the line pulled high, so all ones never matches
                           if (s_r.rx == SIGNATURE)
                           begin
                              s_nxt.idx = sea_pkg::IDX_FIRST_LOAD;
                              s_nxt.st  = sea_pkg::ST_GAP;
                           end
                           else
                           begin
                              s_nxt.absent = 1'b1;
                              s_nxt.st     = sea_pkg::ST_IDLE;
                           end
                        end
                        else
                        begin
                           push = 1'b1;
                           if (s_r.idx == LAST_LOAD)
                           begin
                              s_nxt.loaded = 1'b1;
                              s_nxt.st     = sea_pkg::ST_IDLE;
                           end
                           else
                           begin
                              s_nxt.idx = s_r.idx + 6'h01;
                              s_nxt.st  = sea_pkg::ST_GAP;
                           end
                        end
                     end
                     sea_pkg::OP_WREN:
                     begin
                        s_nxt.op = sea_pkg::OP_WRITE;
                        s_nxt.st = sea_pkg::ST_GAP;
                     end
                     sea_pkg::OP_WRITE:
                        s_nxt.st = sea_pkg::ST_POLL_GAP;
                     sea_pkg::OP_WRDIS:
                     begin
                        s_nxt.done = 1'b1;
                        s_nxt.st   = sea_pkg::ST_IDLE;
                     end
                     default:
                        s_nxt.st = sea_pkg::ST_IDLE;
                  endcase
               end
            end
         end
         sea_pkg::ST_POLL_GAP:
         begin
            if (tick)
            begin
               s_nxt.cs   = 1'b1;
               s_nxt.pcnt = '0;
               s_nxt.st   = sea_pkg::ST_POLL;
            end
         end
         sea_pkg::ST_POLL:
         begin
            // A stuck-low line would hang the block, so the wait is bounded
            if (tick)
            begin
               if (I_MEMORY_DATA_IN || (s_r.pcnt == POLL_LIMIT))
               begin
                  s_nxt.tmo = !I_MEMORY_DATA_IN;
                  s_nxt.cs  = 1'b0;
                  s_nxt.op  = sea_pkg::OP_WRDIS;
                  s_nxt.cnt = '0;
                  s_nxt.st  = sea_pkg::ST_GAP;
               end
               else
                  s_nxt.pcnt = s_r.pcnt + 16'h0001;
            end
         end
         default:
            s_nxt.st = sea_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign O_MEMORY_SERIAL_CLOCK = s_r.sk;
   assign O_MEMORY_SELECT       = s_r.cs;
   assign O_MEMORY_DATA_OUT     = s_r.dout;
   assign O_WR_READY            = (s_r.st == sea_pkg::ST_IDLE);
   assign O_WR_REFUSED          = s_r.refused;
   assign O_WR_DONE             = s_r.done;
   assign O_WR_TIMEOUT          = s_r.tmo;
   assign O_LOAD_DONE           = s_r.loaded;
   assign O_MEMORY_ABSENT       = s_r.absent;
endmodule // sea_loader
`default_nettype wire

/* sea_loader_chk.sv */
// Port-level assertions for the serial memory loader.
// Assumes a bind from the bench onto the loader's top ports.
`timescale 1ns/100ps
`default_nettype none
module sea_loader_chk #(
   parameter logic [5:0] LAST_LOAD = 6'h27
) (
   // Clock and reset
   input wire logic       I_CLK,
   input wire logic       I_RST,
   // Serial pins
   input wire logic       O_MEMORY_SERIAL_CLOCK,
   input wire logic       O_MEMORY_SELECT,
   input wire logic       O_MEMORY_DATA_OUT,
   // Network writes
   input wire logic       I_WR_VALID,
   input wire logic [5:0] I_WR_INDEX,
   input wire logic       O_WR_READY,
   input wire logic       O_WR_REFUSED,
   // Stream and status
   input wire logic       O_CFG_VALID,
   input wire logic [5:0] O_CFG_INDEX,
   input wire logic       O_LOAD_DONE,
   input wire logic       O_MEMORY_ABSENT
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   logic       sk_d_r;
   logic [4:0] bits_r;
   wire        sk_rise = O_MEMORY_SERIAL_CLOCK && !sk_d_r;
   // Polling never clocks, so its count stays zero
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         sk_d_r <= 1'b0;
         bits_r <= 5'h00;
      end
      else
      begin
         sk_d_r <= O_MEMORY_SERIAL_CLOCK;
         bits_r <= !O_MEMORY_SELECT ? 5'h00 : bits_r + {4'h0, sk_rise};
      end
   end
   sequence s_first_rise;
      sk_rise && bits_r == 5'h00 && O_MEMORY_SELECT;
   endsequence
   sequence s_low_req;
      I_WR_VALID && O_WR_READY && I_WR_INDEX <= 6'h10;
   endsequence
   a_sk_framed: assert property (!O_MEMORY_SELECT |-> !O_MEMORY_SERIAL_CLOCK)
      else $error("serial clock active outside a frame");
   a_sel_on_low: assert property ($changed(O_MEMORY_SELECT) |-> !O_MEMORY_SERIAL_CLOCK)
      else $error("select changed while serial clock high");
   a_dout_on_fall: assert property ($changed(O_MEMORY_DATA_OUT) && $past(O_MEMORY_SELECT) && O_MEMORY_SELECT
      |-> $fell(O_MEMORY_SERIAL_CLOCK))
      else $error("data out changed away from a falling edge");
   a_start_bit: assert property (s_first_rise |-> O_MEMORY_DATA_OUT)
      else $error("frame without start bit");
   a_frame_len: assert property ($fell(O_MEMORY_SELECT)
      |-> bits_r == 5'h00 || bits_r == 5'h09 || bits_r == 5'h19)
      else $error("frame length not 9 or 25 clocks");
   a_low_refused: assert property (s_low_req |=> O_WR_REFUSED)
      else $error("protected index not refused");
   a_absent_quiet: assert property (O_MEMORY_ABSENT |-> !O_MEMORY_SELECT && !O_CFG_VALID && !O_LOAD_DONE)
      else $error("activity with memory absent");
   a_ready_late: assert property (O_WR_READY |-> O_LOAD_DONE || O_MEMORY_ABSENT)
      else $error("writes accepted before autoload ended");
   a_cfg_range: assert property (O_CFG_VALID |-> O_CFG_INDEX >= 6'h01 && O_CFG_INDEX <= LAST_LOAD)
      else $error("loaded index out of range");
endmodule // sea_loader_chk
`default_nettype wire

/* sea_loader_tb.sv */
// Self-checking bench: stalled autoload, guarded writes, slow memory, absent memory.
// Assumes the memory model on the serial pins and the checker bound at the foot.
`timescale 1ns/100ps
`default_nettype none
module sea_loader_tb;
   localparam logic [15:0] SIG = 16'h5a3c; // Arbitrary value
   localparam logic [5:0]  LAST = 6'h27;
   typedef struct {
      logic [5:0]  idx;
      logic [15:0] data;
      logic        refused;
   } sea_row_s;
   sea_row_s    rows [0:4];
   logic        clk, rst, sk, cs, dout, di, wr_valid, wr_ready, wr_ref, wr_done, wr_tmo;
   logic        cfg_valid, cfg_ready, load_done, absent, got_ref, got_done, got_tmo, got_bsy, seen;
   logic [5:0]  wr_index, cfg_index, e;
   logic [15:0] wr_data, cfg_data;
   logic [7:0]  mem_div;
   int          n_errors, n_tests, k, n_hi;
   sea_loader #(.SIGNATURE(SIG), .LAST_LOAD(LAST), .POLL_LIMIT(16'h0014)) i_sea_loader (
      .I_CLK(clk), .I_RST(rst), .I_MEM_CLOCK_DIVIDER(mem_div), .O_MEMORY_SERIAL_CLOCK(sk),
      .O_MEMORY_SELECT(cs), .O_MEMORY_DATA_OUT(dout), .I_MEMORY_DATA_IN(di), .I_WR_VALID(wr_valid),
      .I_WR_INDEX(wr_index), .I_WR_DATA(wr_data), .O_WR_READY(wr_ready), .O_WR_REFUSED(wr_ref),
      .O_WR_DONE(wr_done), .O_WR_TIMEOUT(wr_tmo), .O_CFG_VALID(cfg_valid), .O_CFG_INDEX(cfg_index),
      .O_CFG_DATA(cfg_data), .I_CFG_READY(cfg_ready), .O_LOAD_DONE(load_done), .O_MEMORY_ABSENT(absent));
   sea_mem_model i_sea_mem_model (.i_sk(sk), .i_cs(cs), .i_do(dout), .o_di(di));
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_up();
      n_errors++;
      $display("wrong value wait bound expected end seen none");
      final_report();
   endtask
   task automatic do_reset();
      rst = 1'b1;
      repeat (8) @(negedge clk);
      check("reset outputs", 16'h0, {11'h0, cs, wr_ready, cfg_valid, load_done, absent});
      rst = 1'b0;
   endtask
   task automatic net_write(input logic [5:0] idx, input logic [15:0] data);
      {got_ref, got_done, got_tmo, got_bsy} = 4'h0;
      wr_index = idx;
      wr_data = data;
      wr_valid = 1'b1;
      for (k = 0; k < 5000 && wr_ready !== 1'b1; k++)
         @(negedge clk);
      @(negedge clk);
      wr_valid = 1'b0;
      for (k = 0; k < 5000 && !got_ref && !got_done; k++)
      begin
         got_ref = got_ref | wr_ref;
         got_tmo = got_tmo | wr_tmo;
         got_bsy = wr_done ? i_sea_mem_model.busy : got_bsy;
         got_done = got_done | wr_done;
         @(negedge clk);
      end
      if (k >= 5000)
         give_up();
   endtask
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      {rst, wr_valid, cfg_ready, wr_index, wr_data, n_errors, n_tests} = '0;
      mem_div = 8'h01;
      rows = '{'{6'h00, 16'h1111, 1'b1}, '{6'h10, 16'h2222, 1'b1}, '{6'h11, 16'h0f0f, 1'b0},
               '{6'h27, 16'h8001, 1'b0}, '{6'h3f, 16'hfffe, 1'b0}};
      for (int i = 0; i < 64; i++)
         i_sea_mem_model.mem[i] = 16'h3c00 | 16'(i);
      i_sea_mem_model.mem[0] = SIG;
      // Reset from time zero so no clock edge sees unknown state
      do_reset();
      // Far side holds off: a full buffer must stall the load with index 01h at the head
      repeat (3000) @(negedge clk);
      check("stalled load", 16'h0002, {9'h0, cfg_index, load_done});
      e = 6'h01;
      for (k = 0; k < 20000 && e <= LAST; k++)
      begin
         @(negedge clk);
         cfg_ready = (k % 3) != 0;
         if (cfg_valid === 1'b1 && cfg_ready)
         begin
            check("cfg index", {10'h0, e}, {10'h0, cfg_index});
            check("cfg data", 16'h3c00 | {10'h0, e}, cfg_data);
            e = e + 6'h01;
         end
      end
      cfg_ready = 1'b1;
      // The last word leaves at the next edge; look once it has gone
      @(negedge clk);
      for (k = 0; k < 500 && load_done !== 1'b1; k++)
         @(negedge clk);
      check("load end", 16'h2, {14'h0, load_done, cfg_valid});
      $display("test autoload finished");
      for (int r = 0; r < 5; r++)
      begin
         net_write(rows[r].idx, rows[r].data);
         check("refused", {15'h0, rows[r].refused}, {15'h0, got_ref});
         if (!rows[r].refused)
         begin
            check("stored word", rows[r].data, i_sea_mem_model.mem[rows[r].idx]);
            check("write disabled", 16'h0, {15'h0, i_sea_mem_model.wen});
            check("done after ready", 16'h0, {14'h0, got_tmo, got_bsy});
         end
      end
      check("protected word", SIG, i_sea_mem_model.mem[0]);
      $display("test writes finished");
      // Memory stays busy past the poll limit
      i_sea_mem_model.busy_ns = 3000;
      net_write(6'h20, 16'hbeef);
      check("poll timeout", 16'h3, {14'h0, got_tmo, got_done});
      check("start bits", 16'h0, i_sea_mem_model.n_bad[15:0]);
      $display("test timeout finished");
      for (int c = 0; c < 2; c++)
      begin
         i_sea_mem_model.mem[0] = c == 0 ? ~SIG : SIG;
         i_sea_mem_model.absent = c == 1;
         mem_div = 8'(c + 1);
         do_reset();
         seen = 1'b0;
         n_hi = 0;
         repeat (3000)
         begin
            @(negedge clk);
            seen = seen | cfg_valid;
            n_hi += sk;
         end
         check("absent state", 16'h4, {13'h0, absent, seen, load_done});
         check("serial clock high time", 16'(25 * (c + 2)), n_hi[15:0]);
         net_write(6'h20, 16'h1234);
         check("absent write", 16'h1, {15'h0, got_ref});
         $display("test absent memory %0d finished", c);
      end
      final_report();
   end
endmodule // sea_loader_tb
bind sea_loader sea_loader_chk #(.LAST_LOAD(LAST_LOAD)) i_sea_loader_chk (
   .I_CLK(I_CLK), .I_RST(I_RST), .O_MEMORY_SERIAL_CLOCK(O_MEMORY_SERIAL_CLOCK),
   .O_MEMORY_SELECT(O_MEMORY_SELECT), .O_MEMORY_DATA_OUT(O_MEMORY_DATA_OUT), .I_WR_VALID(I_WR_VALID),
   .I_WR_INDEX(I_WR_INDEX), .O_WR_READY(O_WR_READY), .O_WR_REFUSED(O_WR_REFUSED), .O_CFG_VALID(O_CFG_VALID),
   .O_CFG_INDEX(O_CFG_INDEX), .O_LOAD_DONE(O_LOAD_DONE), .O_MEMORY_ABSENT(O_MEMORY_ABSENT));
`default_nettype wire

/* sea_mem_model.sv */
// Behavioural three-wire serial memory with 16-bit words.
// Assumes select active high and a pulled-up data line toward the loader.
`timescale 1ns/100ps
`default_nettype none
module sea_mem_model (
   // Serial pins
   input wire logic i_sk,
   input wire logic i_cs,
   input wire logic i_do,
   output logic     o_di
);
   logic [15:0] mem [0:63];
   logic [24:0] sr;
   logic [4:0]  cnt;
   logic [1:0]  op;
   logic [5:0]  addr;
   logic        wen, pend, busy, drv, bit_q, absent;
   int          busy_ns, n_bad;
   initial
   begin
      {sr, cnt, op, addr, wen, pend, busy, drv, bit_q, absent} = '0;
      busy_ns = 400;
      n_bad = 0;
   end
   // A dropped select aborts any partial frame
   always @(posedge i_sk or negedge i_cs)
   begin
      if (!i_cs)
      begin
         cnt = 5'h00;
         busy = busy | pend;
         pend = 1'b0;
      end
      else
      begin
         cnt = cnt + 5'h01;
         sr = {sr[23:0], i_do};
         if (cnt == 5'h09)
         begin
            n_bad = n_bad + (sr[8] ? 0 : 1);
            op = sr[7:6];
            addr = sr[5:0];
            if (op == 2'h0 && sr[5:4] == 2'h3)
               wen = 1'b1;
            if (op == 2'h0 && sr[5:4] == 2'h0)
               wen = 1'b0;
         end
         if (cnt == 5'h19 && op == 2'h1 && wen)
         begin
            mem[addr] = sr[15:0];
            pend = 1'b1;
         end
      end
   end
   always @(posedge busy)
   begin
      #(busy_ns);
      busy = 1'b0;
   end
   // Word bits move on falling edges so they are steady at the loader's rise
   always @(negedge i_sk)
   begin
      drv = i_cs && op == 2'h2 && cnt >= 5'h09 && cnt < 5'h19;
      bit_q = drv ? mem[addr][5'h18 - cnt] : 1'b1;
   end
   assign o_di = (absent || !(i_cs && (busy || drv))) ? 1'b1 : !busy && bit_q;
endmodule // sea_mem_model
`default_nettype wire

/* sea_pkg.sv */
// Shared constants and types for the serial memory autoload block.
// Assumes a three-wire serial memory with 16-bit words and 6-bit word addresses.
package sea_pkg;

   // Word and frame layout
   localparam int unsigned WORD_W      = 16;
   localparam int unsigned ADDR_W      = 6;
   localparam int unsigned FRAME_W     = 1 + 2 + ADDR_W + WORD_W;
   localparam int unsigned CMD_BITS    = 1 + 2 + ADDR_W;
   localparam logic [4:0]  LAST_BIT_CMD  = 5'h08;
   localparam logic [4:0]  LAST_BIT_DATA = 5'h18;

   // Command codes
   localparam logic [1:0]  CODE_READ   = 2'h2;
   localparam logic [1:0]  CODE_WRITE  = 2'h1;
   localparam logic [3:0]  CODE_WREN   = 4'h3;
   localparam logic [3:0]  CODE_WRDIS  = 4'h0;
   localparam logic        START_BIT   = 1'b1;

   // Word indices
   localparam logic [5:0]  IDX_SIGNATURE    = 6'h00;
   localparam logic [5:0]  IDX_FIRST_LOAD   = 6'h01;
   localparam logic [5:0]  IDX_HW_ADDR_0    = 6'h01;
   localparam logic [5:0]  IDX_NET_ADDR_HI  = 6'h11;
   localparam logic [5:0]  IDX_NET_ADDR_LO  = 6'h12;
   localparam logic [5:0]  IDX_COMM_0       = 6'h24;
   localparam logic [5:0]  IDX_LAST_LOAD    = 6'h27;
   localparam logic [5:0]  IDX_PROTECT_LAST = 6'h10;

   // Timing; gap and poll limit counted in serial clock half periods
   localparam logic [1:0]  GAP_TICKS   = 2'h2;
   localparam int unsigned DIV_W       = 8;
   localparam logic [7:0]  DIV_RESET   = 8'h18;
   localparam logic [15:0] POLL_LIMIT  = 16'hc350;

   // Buffering
   localparam int unsigned FIFO_DEPTH  = 8;

   typedef enum logic [2:0] {
      ST_BOOT,
      ST_IDLE,
      ST_GAP,
      ST_SHIFT,
      ST_POLL_GAP,
      ST_POLL
   } sea_state_e;

   typedef enum logic [1:0] {
      OP_READ,
      OP_WREN,
      OP_WRITE,
      OP_WRDIS
   } sea_op_e;

endpackage
